// file: design/pecr_cfg.svh
// Offsets, field positions, reset values and counts of the extended control registers
`ifndef PECR_CFG_SVH
`define PECR_CFG_SVH

// ==========================================================
// Register offsets on the management bus
`define PECR_OFS_CTRL_A 5'h13
`define PECR_OFS_CTRL_B 5'h14

// ==========================================================
// Field positions of extended_control_a
`define PECR_A_NODE_MODE 15
`define PECR_A_SPEED_SRC 14
`define PECR_A_REMOTE_FAULT 13
`define PECR_A_BANK_HI 12
`define PECR_A_BANK_LO 11
`define PECR_A_XOVER_EN 9
`define PECR_A_XOVER_MAN 8
`define PECR_A_HIZ 7
`define PECR_A_AUTO_PD 0

// Field positions of extended_control_b
`define PECR_B_DRIVE_BOOST 15

// ==========================================================
// Reset values and masks
`define PECR_A_RESET 16'h0201
`define PECR_A_WMASK 16'hdbff
`define PECR_B_RESET 16'h3fe9
`define PECR_BANK_LEGACY 2'h1

// ==========================================================
// Frame coding and counts
`define PECR_PREAMBLE_BITS 6'h20
`define PECR_HDR_LAST 6'h0c
`define PECR_DATA_BITS 6'h10
`define PECR_WDATA_LAST 6'h0f
`define PECR_OP_READ 2'h2
`define PECR_OP_WRITE 2'h1
`define PECR_STRAP_WAIT 2'h3

`endif

// file: design/pecr_pkg.sv
// Types shared by the extended control register bank
package pecr_pkg;

  // Management frame states
  typedef enum logic [2:0] {
    PECR_S_PRE = 3'b000,
    PECR_S_HDR = 3'b001,
    PECR_S_RTA = 3'b010,
    PECR_S_RDATA = 3'b011,
    PECR_S_WTA = 3'b100,
    PECR_S_WDATA = 3'b101
  } pecr_state_t;

  // Control levels handed to the rest of the transceiver
  typedef struct packed {
    logic node_mode_repeater;
    logic speed_100;
    logic [1:0] bank_select;
    logic auto_crossover_enable;
    logic crossover_manual_select;
    logic line_output_hiz_enable;
    logic auto_power_down_100;
    logic drive_strength_boost;
  } pecr_ctrl_t;

endpackage

// file: design/pecr_top.sv
// Extended control registers with their serial management slave
// Functional notes
// - Bit 15 of extended_control_a picks node (0) or unsupported repeater (1); reset from strap.
// - Bit 14 takes speed from the basic control speed bit (0) or only the live speed pin (1).
// - Bits 12:11 select bank 0 for 00 and 1x (offsets 0x14 up) or legacy bank 1 for 01; reset 00.
// - Bit 7 at 1 puts the twisted-pair line outputs in high impedance; reset 0 is normal.
// - Bit 0, reset 1, lets the 100 Mb/s section power down automatically; 0 forbids it.
// - Bit 15 of extended_control_b boosts digital output drive for 1.8 V I/O; reset 0 is normal.
`timescale 1ns/10ps
`include "pecr_cfg.svh"

module pecr_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mdc_pin,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic basic_speed_bit,
  input wire logic speed_pin,
  input wire logic remote_fault,
  input wire logic strap_node_mode,
  input wire logic strap_speed_src,
  output pecr_pkg::pecr_ctrl_t ctrl
);

  // ==========================================================
  // Pin synchronisers
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic mdc_prev_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  logic speed_100_reg;
  logic [15:0] ctrl_a_reg;
  logic [15:0] ctrl_b_reg;
  pecr_pkg::pecr_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [11:0] hdr_reg;
  logic [4:0] addr_reg;
  logic [15:0] shift_reg;

  // Order: mdc, mdio, speed pin, node strap; the speed-source strap is sampled alone
  logic strap_src_s1_reg;
  logic strap_src_s2_reg;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      strap_src_s1_reg <= 1'b0;
      strap_src_s2_reg <= 1'b0;
      mdc_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {mdc_pin, mdio_in, speed_pin, strap_node_mode};
      sync2_reg <= sync1_reg;
      strap_src_s1_reg <= strap_speed_src;
      strap_src_s2_reg <= strap_src_s1_reg;
      mdc_prev_reg <= sync2_reg[3];
    end
  end

  // ==========================================================
  // Frame decode
  wire mdc_rise = sync2_reg[3] & ~mdc_prev_reg;
  wire mdio_bit = sync2_reg[2];
  wire speed_pin_s = sync2_reg[1];
  wire strap_node_s = sync2_reg[0];
  wire [12:0] hdr_full = {hdr_reg, mdio_bit};
  wire [1:0] bank = ctrl_a_reg[`PECR_A_BANK_HI:`PECR_A_BANK_LO];
  wire bank_legacy = (bank == `PECR_BANK_LEGACY);
  wire hit_a = (hdr_full[4:0] == `PECR_OFS_CTRL_A);
  // Offset 0x14 belongs to the extended map, so legacy bank leaves it to others
  wire hit_b = (hdr_full[4:0] == `PECR_OFS_CTRL_B) & ~bank_legacy;
  wire frame_ok = hdr_full[12] & (hdr_full[9:5] == phy_addr) & (hit_a | hit_b);
  wire is_read = frame_ok & (hdr_full[11:10] == `PECR_OP_READ);
  wire is_write = frame_ok & (hdr_full[11:10] == `PECR_OP_WRITE);
  wire [15:0] wdata = {shift_reg[14:0], mdio_bit};
  wire wr_fire = mdc_rise & (state_reg == pecr_pkg::PECR_S_WDATA) & (cnt_reg == `PECR_WDATA_LAST);
  wire wr_a = wr_fire & (addr_reg == `PECR_OFS_CTRL_A);
  wire wr_b = wr_fire & (addr_reg == `PECR_OFS_CTRL_B);
  // Status bits are live, not stored
  wire [15:0] fault_bit = {15'h0000, remote_fault} << `PECR_A_REMOTE_FAULT;
  wire [15:0] read_a = (ctrl_a_reg & `PECR_A_WMASK) | fault_bit;
  wire [15:0] rdata = (addr_reg == `PECR_OFS_CTRL_A) ? read_a : ctrl_b_reg;
  wire strap_load = (strap_cnt_reg == `PECR_STRAP_WAIT) & ~strap_done_reg;

  // ==========================================================
  // Strap capture, delayed until the synchronisers hold settled levels
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
    end
    else if (strap_cnt_reg != `PECR_STRAP_WAIT)
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    else
      strap_done_reg <= 1'b1;
  end

  // ==========================================================
  // Register storage; read-only bits never take written values
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_a_reg <= `PECR_A_RESET;
    else if (strap_load)
    begin
      ctrl_a_reg[`PECR_A_NODE_MODE] <= strap_node_s;
      ctrl_a_reg[`PECR_A_SPEED_SRC] <= strap_src_s2_reg;
    end
    else if (wr_a)
      ctrl_a_reg <= wdata & `PECR_A_WMASK;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_b_reg <= `PECR_B_RESET;
    else if (wr_b)
      ctrl_b_reg <= wdata;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      speed_100_reg <= 1'b0;
    else
      speed_100_reg <= ctrl_a_reg[`PECR_A_SPEED_SRC] ? speed_pin_s : basic_speed_bit;
  end

  // ==========================================================
  // Management frame engine, one step per MDC rising edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= pecr_pkg::PECR_S_PRE;
      cnt_reg <= 6'h00;
      hdr_reg <= 12'h000;
      addr_reg <= 5'h00;
      shift_reg <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end
    else if (mdc_rise)
    begin
      case (state_reg)
        pecr_pkg::PECR_S_PRE:
        begin
          // A zero before a full preamble restarts the count
          if (mdio_bit)
          begin
            if (cnt_reg != `PECR_PREAMBLE_BITS)
              cnt_reg <= cnt_reg + 6'h01;
          end
          else if (cnt_reg == `PECR_PREAMBLE_BITS)
          begin
            state_reg <= pecr_pkg::PECR_S_HDR;
            cnt_reg <= 6'h00;
          end
          else
            cnt_reg <= 6'h00;
        end
        pecr_pkg::PECR_S_HDR:
        begin
          hdr_reg <= hdr_full[11:0];
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == `PECR_HDR_LAST)
          begin
            cnt_reg <= 6'h00;
            addr_reg <= hdr_full[4:0];
            if (is_read)
              state_reg <= pecr_pkg::PECR_S_RTA;
            else if (is_write)
              state_reg <= pecr_pkg::PECR_S_WTA;
            else
              state_reg <= pecr_pkg::PECR_S_PRE;
          end
        end
        pecr_pkg::PECR_S_RTA:
        begin
          // Second turnaround bit is driven low
          mdio_oe <= 1'b1;
          mdio_out <= 1'b0;
          shift_reg <= rdata;
          state_reg <= pecr_pkg::PECR_S_RDATA;
        end
        pecr_pkg::PECR_S_RDATA:
        begin
          if (cnt_reg == `PECR_DATA_BITS)
          begin
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
            cnt_reg <= 6'h00;
            state_reg <= pecr_pkg::PECR_S_PRE;
          end
          else
          begin
            mdio_out <= shift_reg[15];
            shift_reg <= {shift_reg[14:0], 1'b0};
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        pecr_pkg::PECR_S_WTA:
        begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == 6'h01)
          begin
            cnt_reg <= 6'h00;
            state_reg <= pecr_pkg::PECR_S_WDATA;
          end
        end
        pecr_pkg::PECR_S_WDATA:
        begin
          shift_reg <= wdata;
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == `PECR_WDATA_LAST)
          begin
            cnt_reg <= 6'h00;
            state_reg <= pecr_pkg::PECR_S_PRE;
          end
        end
        default:
        begin
          state_reg <= pecr_pkg::PECR_S_PRE;
          cnt_reg <= 6'h00;
          mdio_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Control outputs, all straight from flops
  // line tri-state control
  assign ctrl.line_output_hiz_enable = ctrl_a_reg[`PECR_A_HIZ];
  assign ctrl.auto_power_down_100 = ctrl_a_reg[`PECR_A_AUTO_PD];
  assign ctrl.node_mode_repeater = ctrl_a_reg[`PECR_A_NODE_MODE];
  assign ctrl.speed_100 = speed_100_reg;
  assign ctrl.bank_select = bank;
  assign ctrl.auto_crossover_enable = ctrl_a_reg[`PECR_A_XOVER_EN];
  assign ctrl.crossover_manual_select = ctrl_a_reg[`PECR_A_XOVER_MAN];
  assign ctrl.drive_strength_boost = ctrl_b_reg[`PECR_B_DRIVE_BOOST];

  // ==========================================================
  // Assertions
  a_strap_node_load:
    assert property (@(posedge clk_sys) disable iff (rst)
      $rose(strap_done_reg) |-> ctrl.node_mode_repeater == $past(strap_node_s))
    else $error("node mode not loaded from strap");

  a_speed_source_mux:
    assert property (@(posedge clk_sys) disable iff (rst)
      ##1 ctrl.speed_100 == ($past(ctrl_a_reg[`PECR_A_SPEED_SRC]) ?
        $past(speed_pin_s) : $past(basic_speed_bit)))
    else $error("speed not taken from selected source");

  a_legacy_bank_skip:
    assert property (@(posedge clk_sys) disable iff (rst)
      (mdc_rise && state_reg == pecr_pkg::PECR_S_HDR && cnt_reg == `PECR_HDR_LAST
        && bank_legacy && hdr_full[4:0] == `PECR_OFS_CTRL_B) |=>
        state_reg == pecr_pkg::PECR_S_PRE)
    else $error("extended offset answered in legacy bank");

  a_hiz_follows_write:
    assert property (@(posedge clk_sys) disable iff (rst)
      wr_a |=> (ctrl.line_output_hiz_enable == $past(wdata[`PECR_A_HIZ]))
        ##1 (ctrl.line_output_hiz_enable == $past(wdata[`PECR_A_HIZ], 2)))
    else $error("tri-state control did not take written value");

  a_auto_pd_write:
    assert property (@(posedge clk_sys) disable iff (rst)
      wr_a |=> ctrl.auto_power_down_100 == $past(wdata[`PECR_A_AUTO_PD]))
    else $error("power-down permit did not take written value");

  a_drive_boost_hold:
    assert property (@(posedge clk_sys) disable iff (rst)
      !wr_b |=> $stable(ctrl.drive_strength_boost))
    else $error("drive strength changed without a write");

endmodule // pecr_top

// file: testbench/pecr_sta_model.sv
// Station management master model that runs MDIO frames
`timescale 1ns/10ps

module pecr_sta_model (
  input wire logic clk_sys,
  input wire logic mdio_wire,
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_en
);
  // ==========================================================
  // Idle: clock stands low, line released
  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b0;
    mdio_en = 1'b0;
  end

  // One bit slot, 5 clk per phase, well above the 3 clk sync delay
  task automatic slot(input logic en, input logic val, output logic seen);
    mdio_en = en;
    mdio_drv = val;
    repeat (5) @(negedge clk_sys);
    seen = mdio_wire;
    mdc = 1'b1;
    repeat (5) @(negedge clk_sys);
    mdc = 1'b0;
  endtask

  // Full frame; a read releases the line from the first turnaround bit
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ofs,
    input logic [15:0] wdata, output logic [15:0] rdata, output logic ta_seen);
    logic [45:0] hdr;
    logic s;
    logic wr;
    hdr = {32'hffffffff, 2'b01, op, phy, ofs};
    wr = (op != 2'h2);
    for (int i = 45; i >= 0; i--) slot(1'b1, hdr[i], s);
    slot(wr, 1'b1, s);
    slot(wr, 1'b0, ta_seen);
    for (int i = 15; i >= 0; i--) slot(wr, wdata[i], rdata[i]);
    mdio_en = 1'b0;
    repeat (10) @(negedge clk_sys);
  endtask

  task automatic rmw(input logic [4:0] phy, input logic [4:0] ofs,
    input logic [15:0] setm, input logic [15:0] clrm);
    logic [15:0] cur;
    logic [15:0] junk;
    logic t;
    frame(2'h2, phy, ofs, 16'h0000, cur, t);
    frame(2'h1, phy, ofs, (cur & ~clrm) | setm, junk, t);
  endtask
endmodule // pecr_sta_model

// file: testbench/testbench.sv
// Self-checking bench for the extended control register bank
`timescale 1ns/10ps
`include "pecr_cfg.svh"
`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module testbench;
  localparam logic [4:0] ADDR = 5'h05;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic basic_speed_bit = 1'b0;
  logic speed_pin = 1'b0;
  logic remote_fault = 1'b0;
  logic strap_node_mode = 1'b1;
  logic strap_speed_src = 1'b0;
  logic mdc, mdio_drv, mdio_en, mdio_out, mdio_oe, mdio_wire;
  pecr_pkg::pecr_ctrl_t ctrl;
  logic [15:0] rd;
  logic ta;
  int error_cnt = 0;
  int samples_checked = 0;

  // Pull-up on the shared line when nobody drives it
  assign mdio_wire = mdio_oe ? mdio_out : (mdio_en ? mdio_drv : 1'b1);

  always #10 clk_sys = ~clk_sys;

  pecr_sta_model sta_u (.clk_sys(clk_sys), .mdio_wire(mdio_wire), .mdc(mdc),
    .mdio_drv(mdio_drv), .mdio_en(mdio_en));

  pecr_top dut_u (.clk_sys(clk_sys), .rst(rst), .mdc_pin(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(ADDR),
    .basic_speed_bit(basic_speed_bit), .speed_pin(speed_pin), .remote_fault(remote_fault),
    .strap_node_mode(strap_node_mode), .strap_speed_src(strap_speed_src), .ctrl(ctrl));

  // ==========================================================
  // Bus helpers
  task automatic rd_reg(input logic [4:0] ofs);
    sta_u.frame(2'h2, ADDR, ofs, 16'h0000, rd, ta);
  endtask

  task automatic wr_reg(input logic [4:0] ofs, input logic [15:0] v);
    logic [15:0] junk;
    sta_u.frame(2'h1, ADDR, ofs, v, junk, ta);
  endtask

  task automatic t_reset();
    `CHK("repeater", 1'b1, ctrl.node_mode_repeater);
    `CHK("bank", 2'h0, ctrl.bank_select);
    `CHK("hiz", 1'b0, ctrl.line_output_hiz_enable);
    `CHK("auto_pd", 1'b1, ctrl.auto_power_down_100);
    `CHK("boost", 1'b0, ctrl.drive_strength_boost);
    `CHK("xover_en", 1'b1, ctrl.auto_crossover_enable);
    `CHK("xover_man", 1'b0, ctrl.crossover_manual_select);
    rd_reg(`PECR_OFS_CTRL_A);
    `CHK("ctrl_a", 16'h8201, rd);
    `CHK("turnaround", 1'b0, ta);
    rd_reg(`PECR_OFS_CTRL_B);
    `CHK("ctrl_b", 16'h3fe9, rd);
    $display("test reset done");
  endtask

  // Speed from the live pin only, bank 1x still reaches 0x14
  task automatic t_write_all();
    remote_fault = 1'b1;
    wr_reg(`PECR_OFS_CTRL_A, 16'hffff);
    rd_reg(`PECR_OFS_CTRL_A);
    `CHK("ctrl_a", 16'hfbff, rd);
    `CHK("hiz", 1'b1, ctrl.line_output_hiz_enable);
    `CHK("xover_man", 1'b1, ctrl.crossover_manual_select);
    speed_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK("speed pin", 1'b1, ctrl.speed_100);
    speed_pin = 1'b0;
    basic_speed_bit = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK("speed pin", 1'b0, ctrl.speed_100);
    rd_reg(`PECR_OFS_CTRL_B);
    `CHK("bank 1x", 16'h3fe9, rd);
    $display("test write_all done");
  endtask

  // Speed from the control bit
  task automatic t_speed();
    remote_fault = 1'b0;
    wr_reg(`PECR_OFS_CTRL_A, 16'h0001);
    `CHK("speed bit", 1'b1, ctrl.speed_100);
    `CHK("hiz", 1'b0, ctrl.line_output_hiz_enable);
    basic_speed_bit = 1'b0;
    speed_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHK("speed bit", 1'b0, ctrl.speed_100);
    $display("test speed done");
  endtask

  // Legacy bank hides 0x14; auto power-down cleared
  task automatic t_bank();
    sta_u.rmw(ADDR, `PECR_OFS_CTRL_A, 16'h0800, 16'h0001);
    `CHK("bank", 2'h1, ctrl.bank_select);
    `CHK("auto_pd", 1'b0, ctrl.auto_power_down_100);
    rd_reg(`PECR_OFS_CTRL_B);
    `CHK("hidden", 16'hffff, rd);
    `CHK("no turnaround", 1'b1, ta);
    rd_reg(`PECR_OFS_CTRL_A);
    `CHK("ctrl_a", 16'h0800, rd);
    sta_u.rmw(ADDR, `PECR_OFS_CTRL_A, 16'h0001, 16'h0800);
    `CHK("auto_pd", 1'b1, ctrl.auto_power_down_100);
    $display("test bank done");
  endtask

  // Drive boost kept with reserved bits; foreign address ignored
  task automatic t_boost();
    sta_u.rmw(ADDR, `PECR_OFS_CTRL_B, 16'h8000, 16'h0000);
    `CHK("boost", 1'b1, ctrl.drive_strength_boost);
    rd_reg(`PECR_OFS_CTRL_B);
    `CHK("ctrl_b", 16'hbfe9, rd);
    sta_u.frame(2'h2, ADDR ^ 5'h01, `PECR_OFS_CTRL_A, 16'h0000, rd, ta);
    `CHK("other addr", 16'hffff, rd);
    $display("test boost done");
  endtask

  // Mid-run reset with opposite straps; speed pin is still high here
  task automatic t_straps();
    strap_node_mode = 1'b0;
    strap_speed_src = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK("node strap", 1'b0, ctrl.node_mode_repeater);
    `CHK("boost reset", 1'b0, ctrl.drive_strength_boost);
    `CHK("pin speed", 1'b1, ctrl.speed_100);
    rd_reg(`PECR_OFS_CTRL_A);
    `CHK("ctrl_a strap", 16'h4201, rd);
    $display("test straps done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence; straps settle 4 clk after release
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    t_reset();
    t_write_all();
    t_speed();
    t_bank();
    t_boost();
    t_straps();
    results();
  end

  // Watchdog, about four times the expected run
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
endmodule // testbench
